// ### src/gsec_pkg.sv
// package for the service-request, status and end-marker block
// Summary of operation
// - With end marker on, drive end-or-identify with the last byte of each string.
// - End marker setting: zero asserts on last byte, one suppresses entirely.
// - Reset, device clear or selected clear restore end marker to assert-on-last.
// - Dump formats assert end-or-identify only on the final byte of the whole dump.
// - Formats zero and one report display location; two and three the buffer pointer.
// - Dump formats assemble the whole buffer before the first byte goes out.
// - Flag error on illegal command, illegal option, or programming while not remote.
// - Flag over-limit whenever the compliance limit is exceeded.
// - Flag end-of-buffer when a running program reaches end of memory.
// - Flag end-of-dwell each time a dwell interval expires while running.
// - Flag port-change whenever any auxiliary input line changes.
// - Reset, device clear or selected clear zero the service-request mask.
// - Mask value 0 to 31 is written by the controller and loaded whole.
// - Mask weights: 1 error, 2 over-limit, 4 end-buffer, 8 dwell, 16 port.
// - Any event with its mask bit set raises service request.
// - Status byte is returned on serial poll; only path to event information.
// - Status bit 6 set when this device requests service.
// - With status bit 5 set, bits 0 to 3 carry error flags.
// - With status bit 5 clear, bits 0 to 3 carry data flags.
// - Error bits: command, option, not remote, unused; data: limit, buffer, dwell, port.
// - Service request stays asserted until the status byte is read by serial poll, or until reset or device clear.
package gsec_pkg;
  localparam int unsigned MASK_W = 5;
  localparam logic [MASK_W-1:0] MASK_RESET = 5'h00;
  localparam logic [4:0] MASK_MAX = 5'h1f;
  localparam int unsigned BIT_ERR = 0;
  localparam int unsigned BIT_LIMIT = 1;
  localparam int unsigned BIT_BUF = 2;
  localparam int unsigned BIT_DWELL = 3;
  localparam int unsigned BIT_PORT = 4;
  localparam int unsigned SB_RQS = 6;
  localparam int unsigned SB_ERR = 5;
  localparam logic end_marker_on = 1'b0;
  localparam logic end_marker_off = 1'b1;
  localparam logic [7:0] SB_ZERO = 8'h00;

  typedef enum logic [2:0] {
    format_location_prefixed = 3'b000,
    format_location_bare = 3'b001,
    format_buffer_prefixed = 3'b010,
    format_buffer_bare = 3'b011,
    format_dump_prefixed = 3'b100,
    format_dump_bare = 3'b101
  } gsec_format_type;

  typedef enum logic [1:0] {
    GSEC_IDLE = 2'b00,
    GSEC_ASSEMBLE = 2'b01,
    GSEC_SEND = 2'b10
  } gsec_state_type;

  // error sources arriving as one-cycle pulses
  typedef struct packed {
    logic illegal_command_flag;
    logic illegal_option_flag;
    logic not_remote;
  } gsec_err_type;

  // outgoing byte with its end-or-identify mark
  typedef struct packed {
    logic [7:0] data;
    logic eoi;
  } gsec_byte_type;
endpackage : gsec_pkg

// ### src/gsec_top.sv
// service request, serial-poll status byte and end-marker control
module gsec_top
  import gsec_pkg::*;
#(
  parameter int unsigned PORT_W = 4,
  parameter int unsigned ADDR_W = 7
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // device clear and selected device clear pulses
  input wire logic dev_clear_i,
  // parsed command strobes
  input wire logic mask_wr_i,
  input wire logic [7:0] mask_val_i,
  input wire logic end_marker_wr_i,
  input wire logic end_marker_val_i,
  input wire logic format_wr_i,
  input wire logic [2:0] format_val_i,
  // internal events
  input wire gsec_err_type err_i,
  input wire logic over_limit_i,
  input wire logic end_of_buffer_i,
  input wire logic dwell_expired_i,
  input wire logic program_running_i,
  input wire logic [PORT_W-1:0] port_in_i,
  // serial poll
  input wire logic spoll_rd_i,
  output logic [7:0] status_byte_o,
  output logic srq_o,
  // talker byte stream from string builder
  input wire logic talk_start_i,
  input wire logic [ADDR_W-1:0] location_ptr_i,
  input wire logic [ADDR_W-1:0] buffer_ptr_i,
  output logic [ADDR_W-1:0] report_ptr_o,
  output logic dump_mode_o,
  input wire logic assembly_done_i,
  input wire logic src_valid_i,
  input wire logic [7:0] src_data_i,
  input wire logic src_last_i,
  input wire logic src_dump_last_i,
  output logic src_ready_o,
  output gsec_byte_type tx_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic format_bad_o
);

  initial begin
    if (PORT_W < 1 || ADDR_W < 1) begin
      $error("gsec_top: widths must be at least one");
    end
  end

  logic [MASK_W-1:0] mask;
  logic end_marker;
  gsec_format_type format;
  logic [3:0] err_flags;
  logic [3:0] data_flags;
  logic [PORT_W-1:0] port_q;
  logic srq;
  gsec_state_type state;
  logic [MASK_W-1:0] events;
  logic is_dump;
  logic ev_err;

  assign ev_err = err_i.illegal_command_flag | err_i.illegal_option_flag | err_i.not_remote;
  assign events[BIT_ERR] = ev_err;
  assign events[BIT_LIMIT] = over_limit_i;
  assign events[BIT_BUF] = end_of_buffer_i & program_running_i;
  assign events[BIT_DWELL] = dwell_expired_i & program_running_i;
  assign events[BIT_PORT] = |(port_in_i ^ port_q);
  assign is_dump = (format == format_dump_prefixed) || (format == format_dump_bare);

  // mask: loaded whole, cleared on reset and device clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask <= MASK_RESET;
    end else if (dev_clear_i) begin
      mask <= MASK_RESET;
    end else if (mask_wr_i && mask_val_i <= {3'h0, MASK_MAX}) begin
      mask <= mask_val_i[MASK_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      end_marker <= end_marker_on;
    end else if (dev_clear_i) begin
      end_marker <= end_marker_on;
    end else if (end_marker_wr_i) begin
      end_marker <= end_marker_val_i;
    end
  end

  // out-of-range format codes are refused and flagged
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      format <= format_location_prefixed;
      format_bad_o <= 1'b0;
    end else begin
      format_bad_o <= format_wr_i && format_val_i > 3'h5;
      if (dev_clear_i) begin
        format <= format_location_prefixed;
      end else if (format_wr_i && format_val_i <= 3'h5) begin
        format <= gsec_format_type'(format_val_i);
      end
    end
  end

  // port history: reset loads zero as baseline, so a nonzero first sample counts as a change
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_q <= '0;
    end else begin
      port_q <= port_in_i;
    end
  end

  // condition flags; set wins over the poll clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      err_flags <= 4'h0;
      data_flags <= 4'h0;
    end else if (dev_clear_i) begin
      err_flags <= 4'h0;
      data_flags <= 4'h0;
    end else begin
      err_flags <= (spoll_rd_i ? 4'h0 : err_flags)
        | {1'b0, err_i.not_remote, err_i.illegal_option_flag, err_i.illegal_command_flag};
      data_flags <= (spoll_rd_i ? 4'h0 : data_flags) | events[BIT_PORT:BIT_LIMIT];
    end
  end

  // request held until polled; a new masked event in the poll cycle keeps it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      srq <= 1'b0;
    end else if (dev_clear_i) begin
      srq <= 1'b0;
    end else if (|(events & mask)) begin
      srq <= 1'b1;
    end else if (spoll_rd_i) begin
      srq <= 1'b0;
    end
  end

  assign srq_o = srq;

  // status byte is combinational so the poll returns the live picture
  always_comb begin
    status_byte_o = SB_ZERO;
    status_byte_o[SB_RQS] = srq;
    status_byte_o[SB_ERR] = |err_flags;
    status_byte_o[3:0] = (|err_flags) ? err_flags : data_flags;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      report_ptr_o <= '0;
    end else if (format == format_location_prefixed || format == format_location_bare) begin
      report_ptr_o <= location_ptr_i;
    end else begin
      report_ptr_o <= buffer_ptr_i;
    end
  end

  assign dump_mode_o = is_dump;

  // talker: dump formats wait for the whole buffer to be built first
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= GSEC_IDLE;
    end else begin
      unique case (state)
        GSEC_IDLE: begin
          if (talk_start_i) begin
            state <= is_dump ? GSEC_ASSEMBLE : GSEC_SEND;
          end
        end
        GSEC_ASSEMBLE: begin
          if (assembly_done_i) begin
            state <= GSEC_SEND;
          end
        end
        GSEC_SEND: begin
          if (src_valid_i && src_ready_o && (is_dump ? src_dump_last_i : src_last_i)) begin
            state <= GSEC_IDLE;
          end
        end
        default: state <= GSEC_IDLE;
      endcase
    end
  end

  // single-entry output register, refilled when drained
  assign src_ready_o = (state == GSEC_SEND) && (!tx_valid_o || tx_ready_i);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_o <= '0;
      tx_valid_o <= 1'b0;
    end else begin
      if (src_valid_i && src_ready_o) begin
        tx_o.data <= src_data_i;
        tx_o.eoi <= (end_marker == end_marker_on)
          && (is_dump ? src_dump_last_i : src_last_i);
        tx_valid_o <= 1'b1;
      end else if (tx_ready_i) begin
        tx_valid_o <= 1'b0;
      end
    end
  end

  mask_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    dev_clear_i |=> mask == MASK_RESET && end_marker == end_marker_on)
    else $error("clear did not reset mask or end marker");
  mask_load_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    mask_wr_i && !dev_clear_i && mask_val_i <= 8'h1f |=> mask == $past(mask_val_i[4:0]))
    else $error("mask not loaded whole");
  srq_raise_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !dev_clear_i && |(events & mask) |=> srq_o)
    else $error("masked event did not raise request");
  srq_none_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    mask == 5'h00 && !srq_o && !mask_wr_i |=> !srq_o)
    else $error("request raised with empty mask");
  srq_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    srq_o && !spoll_rd_i && !dev_clear_i |=> srq_o)
    else $error("request dropped before poll");
  rqs_bit_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    status_byte_o[6] == srq_o && status_byte_o[7] == 1'b0 && status_byte_o[4] == 1'b0)
    else $error("status bits 6, 7 or 4 wrong");
  err_view_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !dev_clear_i && err_i.illegal_command_flag |=> status_byte_o[5] && status_byte_o[0])
    else $error("illegal command not shown");
  eoi_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tx_valid_o && end_marker == end_marker_off && $stable(end_marker) |-> !tx_o.eoi)
    else $error("end marker sent while suppressed");
  dump_eoi_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    src_valid_i && src_ready_o && is_dump && !src_dump_last_i |=> !tx_o.eoi)
    else $error("end marker inside dump");
  dump_wait_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == GSEC_ASSEMBLE && !assembly_done_i |=> !src_ready_o)
    else $error("dump sent before assembly");
  ptr_sel_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    format == format_buffer_bare && $stable(format) |=> report_ptr_o == $past(buffer_ptr_i))
    else $error("buffer pointer not reported");

  // end-marker and mask loading
  marker_load_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    end_marker_wr_i && !dev_clear_i |=> end_marker == $past(end_marker_val_i))
    else $error("end marker setting not loaded");

  mask_refuse_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    mask_wr_i && !dev_clear_i && mask_val_i > 8'h1f |=> $stable(mask))
    else $error("out of range mask accepted");

  srq_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    dev_clear_i |=> !srq_o)
    else $error("clear did not drop request");

  err_event_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ev_err && mask[BIT_ERR] && !dev_clear_i |=> srq_o)
    else $error("masked error did not raise request");

  // poll releases request and flags unless a new event lands
  poll_release_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    spoll_rd_i && !dev_clear_i && !(|(events & mask)) |=> !srq_o)
    else $error("request not released by poll");

  poll_flags_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    spoll_rd_i && !dev_clear_i && !ev_err && !(|events[BIT_PORT:BIT_LIMIT])
    |=> status_byte_o[5:0] == 6'h00)
    else $error("poll did not clear flags");

  status_zero_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !srq_o && err_flags == 4'h0 && data_flags == 4'h0 |-> status_byte_o == SB_ZERO)
    else $error("status byte not zero when idle");

  // flag meanings
  err_option_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !dev_clear_i && err_i.illegal_option_flag |=> status_byte_o[5] && status_byte_o[1])
    else $error("illegal option not shown");

  err_remote_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !dev_clear_i && err_i.not_remote |=> status_byte_o[5] && status_byte_o[2])
    else $error("not remote not shown");

  err_unused_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    status_byte_o[5] |-> !status_byte_o[3])
    else $error("unused error bit set");

  data_view_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !status_byte_o[5] |-> status_byte_o[3:0] == data_flags)
    else $error("data flags not shown");

  limit_flag_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !dev_clear_i && over_limit_i |=> data_flags[0])
    else $error("over limit not flagged");

  buffer_flag_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !dev_clear_i && end_of_buffer_i && program_running_i |=> data_flags[1])
    else $error("end of buffer not flagged");

  dwell_flag_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !dev_clear_i && dwell_expired_i && program_running_i |=> data_flags[2])
    else $error("end of dwell not flagged");

  port_flag_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !dev_clear_i && port_in_i != port_q |=> data_flags[3])
    else $error("port change not flagged");

  // format and pointer selection
  ptr_loc_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    format == format_location_prefixed && $stable(format)
    |=> report_ptr_o == $past(location_ptr_i))
    else $error("location pointer not reported");

  fmt_refuse_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    format_wr_i && !dev_clear_i && format_val_i > 3'h5 |=> format_bad_o && $stable(format))
    else $error("bad format not refused");

  fmt_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    dev_clear_i |=> format == format_location_prefixed)
    else $error("clear did not restore format");

  // talker stream
  idle_ready_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == GSEC_IDLE |-> !src_ready_o)
    else $error("byte taken while idle");

  eoi_last_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    src_valid_i && src_ready_o && !is_dump && src_last_i && end_marker == end_marker_on
    |=> tx_o.eoi)
    else $error("last byte lacks end marker");

  dump_last_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    src_valid_i && src_ready_o && is_dump && src_dump_last_i && end_marker == end_marker_on
    |=> tx_o.eoi)
    else $error("dump end lacks end marker");

  tx_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_o))
    else $error("byte changed before taken");

endmodule : gsec_top

// ### bench/gsec_ctrl_model.sv
// bus controller model taking talker bytes with a stall pattern
module gsec_ctrl_model
  import gsec_pkg::*;
(
  // clock
  input wire logic clk_i,
  // talker stream
  input wire gsec_byte_type tx_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  // totals seen
  output int n_rx_o,
  output int n_eoi_o,
  output logic [7:0] eoi_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] stall = 3'h5;
  initial begin
    n_rx_o = 0;
    n_eoi_o = 0;
    eoi_data_o = 8'h00;
  end
  // moves on the rising edge so the bench sees it settled
  always @(posedge clk_i) begin
    stall <= {stall[1:0], stall[2]};
    if (tx_valid_i && tx_ready_o) begin
      n_rx_o <= n_rx_o + 1;
      if (tx_i.eoi) begin
        n_eoi_o <= n_eoi_o + 1;
        eoi_data_o <= tx_i.data;
      end
    end
  end
  assign tx_ready_o = stall[0];
endmodule : gsec_ctrl_model

// ### bench/testbench.sv
// self-checking bench of the status, service-request and end-marker block
module testbench
  import gsec_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 0, resetn_i = 0, dev_clear_i = 0, mask_wr_i = 0, end_marker_wr_i = 0;
  logic end_marker_val_i = 0, format_wr_i = 0, over_limit_i = 0, end_of_buffer_i = 0;
  logic dwell_expired_i = 0, program_running_i = 0, spoll_rd_i = 0, talk_start_i = 0;
  logic assembly_done_i = 0, src_valid_i = 0, src_last_i = 0, src_dump_last_i = 0;
  logic [7:0] mask_val_i = 0, src_data_i = 0, status_byte_o, eoi_data, lf = 8'h46;
  logic [2:0] format_val_i = 0;
  logic [3:0] port_in_i = 0;
  logic [6:0] report_ptr_o;
  logic srq_o, dump_mode_o, src_ready_o, tx_valid_o, tx_ready_i;
  gsec_err_type err_i = '0;
  gsec_byte_type tx_o;
  int n_fail = 0, total_checks = 0, n_rx, n_eoi, m, e, i;
  always #2.5 clk_i = ~clk_i;
  gsec_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .dev_clear_i(dev_clear_i),
    .mask_wr_i(mask_wr_i), .mask_val_i(mask_val_i), .end_marker_wr_i(end_marker_wr_i),
    .end_marker_val_i(end_marker_val_i), .format_wr_i(format_wr_i),
    .format_val_i(format_val_i), .err_i(err_i), .over_limit_i(over_limit_i),
    .end_of_buffer_i(end_of_buffer_i), .dwell_expired_i(dwell_expired_i),
    .program_running_i(program_running_i), .port_in_i(port_in_i), .spoll_rd_i(spoll_rd_i),
    .status_byte_o(status_byte_o), .srq_o(srq_o), .talk_start_i(talk_start_i),
    .location_ptr_i(7'h15), .buffer_ptr_i(7'h2a), .report_ptr_o(report_ptr_o),
    .dump_mode_o(dump_mode_o), .assembly_done_i(assembly_done_i), .src_valid_i(src_valid_i),
    .src_data_i(src_data_i), .src_last_i(src_last_i), .src_dump_last_i(src_dump_last_i),
    .src_ready_o(src_ready_o), .tx_o(tx_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .format_bad_o());
  gsec_ctrl_model ctl (.clk_i(clk_i), .tx_i(tx_o), .tx_valid_i(tx_valid_o),
    .tx_ready_o(tx_ready_i), .n_rx_o(n_rx), .n_eoi_o(n_eoi), .eoi_data_o(eoi_data));
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  function automatic logic [8:0] exp_sb(input int ev);
    return (ev == 0) ? 9'h061 : 9'h040 | (9'h1 << (ev - 1));
  endfunction : exp_sb
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // one strobe or event, then settle; pulses drop after one cycle
  task automatic cmd(input int k, input logic [7:0] v);
    @(negedge clk_i);
    case (k)
      0: begin mask_wr_i = 1; mask_val_i = v; end
      1: begin end_marker_wr_i = 1; end_marker_val_i = v[0]; end
      2: begin format_wr_i = 1; format_val_i = v[2:0]; end
      3: spoll_rd_i = 1;
      4: dev_clear_i = 1;
      5: err_i = gsec_err_type'(v[2:0]);
      6: {over_limit_i, end_of_buffer_i, dwell_expired_i} = v[2:0];
      default: port_in_i = port_in_i ^ v[3:0];
    endcase
    @(negedge clk_i);
    {mask_wr_i, end_marker_wr_i, format_wr_i, spoll_rd_i, dev_clear_i} = '0;
    {err_i, over_limit_i, end_of_buffer_i, dwell_expired_i} = '0;
    @(negedge clk_i);
  endtask : cmd
  task automatic ev(input int k);
    if (k == 0) cmd(5, 8'h4);
    else if (k < 4) cmd(6, 8'h4 >> (k - 1));
    else cmd(7, 8'h1);
  endtask : ev
  // stream n bytes; dump streams also mark each location end
  task automatic talk(input int n, input logic dump, input int eo);
    int r0, e0;
    r0 = n_rx;
    e0 = n_eoi;
    cmd(8, 8'h0);
    talk_start_i = 1;
    @(negedge clk_i);
    talk_start_i = 0;
    if (dump) begin
      repeat (3) @(negedge clk_i);
      chk(9'(src_ready_o), 9'h0);
      assembly_done_i = 1;
      @(negedge clk_i);
      assembly_done_i = 0;
    end
    for (int j = 0; j < n; j++) begin
      src_valid_i = 1;
      src_data_i = 8'h30 + 8'(j);
      src_last_i = dump ? j[0] : (j == n - 1);
      src_dump_last_i = (j == n - 1);
      while (!src_ready_o) @(negedge clk_i);
      @(negedge clk_i);
    end
    src_valid_i = 0;
    repeat (8) @(negedge clk_i);
    chk(9'(n_rx - r0), 9'(n));
    chk(9'(n_eoi - e0), 9'(eo));
    if (eo > 0) chk(9'(eoi_data), 9'h30 + 9'(n - 1));
  endtask : talk
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(negedge clk_i);
    resetn_i = 1;
    program_running_i = 1;
    @(negedge clk_i);
    chk({srq_o, status_byte_o}, 9'h0);
    cmd(0, 8'h2);
    cmd(0, 8'h28);
    ev(1);
    chk({srq_o, status_byte_o}, 9'h141);
    cmd(3, 8'h0);
    cmd(0, 8'h1);
    for (i = 0; i < 3; i++) begin
      cmd(5, 8'h4 >> i);
      chk({srq_o, status_byte_o}, 9'h160 | (9'h1 << i));
      cmd(3, 8'h0);
    end
    program_running_i = 0;
    cmd(0, 8'h8);
    ev(3);
    chk(9'(srq_o), 9'h0);
    program_running_i = 1;
    cmd(3, 8'h0);
    cmd(0, 8'h1f);
    cmd(4, 8'h0);
    ev(1);
    chk(9'(srq_o), 9'h0);
    cmd(3, 8'h0);
    chk({srq_o, status_byte_o}, 9'h0);
    for (i = 0; i < 16; i++) begin
      lf = lfsr_next(lf);
      m = lf[4:0];
      e = lf % 5;
      cmd(0, 8'(m));
      ev(e);
      if (m[e]) chk({srq_o, status_byte_o}, 9'h100 | exp_sb(e));
      else chk(9'(srq_o), 9'h0);
      cmd(3, 8'h0);
      chk({srq_o, status_byte_o}, 9'h0);
    end
    for (i = 0; i < 6; i++) begin
      cmd(2, 8'(i));
      chk(9'(dump_mode_o), 9'(i > 3));
      if (i < 4) chk(9'(report_ptr_o), (i < 2) ? 9'h15 : 9'h2a);
    end
    cmd(2, 8'h0);
    cmd(1, 8'h0);
    talk(3, 0, 1);
    cmd(1, 8'h1);
    talk(3, 0, 0);
    cmd(4, 8'h0);
    talk(3, 0, 1);
    cmd(2, 8'h4);
    talk(4, 1, 1);
    report_and_stop();
  end
endmodule : testbench
